// >>> common/ltrs_pkg.sv
package ltrs_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0] CTRL_OFFSET = 4'h0;
	localparam logic [3:0] STATUS_OFFSET = 4'h4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// control field positions
	// ----------------------------------------------------------------
	localparam int RISE_EN_BIT = 0;
	localparam int FALL_EN_BIT = 1;
	localparam int SRC_LSB = 2;
	localparam int SRC_MSB = 4;
	localparam int RISE_EDGE_BIT = 6;
	localparam int FALL_EDGE_BIT = 7;
	localparam logic [7:0] CTRL_WMASK = 8'hDF;

	// ----------------------------------------------------------------
	// timing: timer clock is the instruction clock, system clock / 4
	// ----------------------------------------------------------------
	localparam int TICK_DIV = 4;

	typedef enum logic [2:0] {
		SRC_CAPCOMP = 3'h0,
		SRC_COMP_A = 3'h1,
		SRC_COMP_B = 3'h2,
		SRC_FAULT = 3'h3,
		SRC_OUT_ZERO = 3'h4,
		SRC_OUT_ONE = 3'h5
	} ltrs_src_t;

	typedef struct packed {
		logic fallEdgeSensitive;
		logic riseEdgeSensitive;
		logic unused5;
		logic [2:0] extResetSourceSel;
		logic fallEventResetEn;
		logic riseEventResetEn;
	} ltrs_ctrl_t;

	typedef struct packed {
		logic capcompOutput;
		logic comparatorAOutput;
		logic comparatorBOutput;
		logic outgenFaultInput;
		logic outgenOutputZero;
		logic outgenOutputOne;
	} ltrs_sources_t;

endpackage : ltrs_pkg

// >>> rtl/ltrs_sync.sv
`timescale 1ns/1ps
module ltrs_sync #(
	parameter int WIDTH = 6
) (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage1_ff;
	logic [WIDTH-1:0] stage2_ff;
	logic [WIDTH-1:0] nxt_stage1;
	logic [WIDTH-1:0] nxt_stage2;

	// a zero-width bank would leave the select with nothing to read
	if (WIDTH < 1) begin : g_width_check
		$error("sync width must be at least one");
	end

	always_comb begin
		nxt_stage1 = din;
		nxt_stage2 = stage1_ff;
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end else begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
		end
	end

	assign dout = stage2_ff;

endmodule : ltrs_sync

// >>> rtl/ltrs_top.sv
`timescale 1ns/1ps
module ltrs_top (
	// clock and reset
	input wire logic clock,
	input wire logic nrst,
	// axi4-lite write address
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// peripheral reset sources, asynchronous
	input wire ltrs_pkg::ltrs_sources_t sources,
	// timer side
	input wire logic countWriteStrobe,
	output logic timerTick,
	output logic countClear
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ltrs_pkg::ltrs_ctrl_t ctrl_ff, nxt_ctrl;
	logic awHeld_ff, nxt_awHeld;
	logic [3:0] awAddr_ff, nxt_awAddr;
	logic wHeld_ff, nxt_wHeld;
	logic [31:0] wData_ff, nxt_wData;
	logic [3:0] wStrb_ff, nxt_wStrb;
	logic bValid_ff, nxt_bValid;
	logic [1:0] bResp_ff, nxt_bResp;
	logic rValid_ff, nxt_rValid;
	logic [31:0] rData_ff, nxt_rData;
	logic [1:0] rResp_ff, nxt_rResp;
	logic [1:0] div_ff, nxt_div;
	logic prev_ff, nxt_prev;
	logic riseSeen_ff, nxt_riseSeen;
	logic fallSeen_ff, nxt_fallSeen;
	logic clear_ff, nxt_clear;
	logic clearCount_ff, nxt_clearCount;

	ltrs_pkg::ltrs_sources_t srcSync;
	logic selSrc;
	logic tick;
	logic doWrite;
	logic reqRise;
	logic reqFall;

	// ----------------------------------------------------------------
	// source synchroniser and select
	// ----------------------------------------------------------------
	ltrs_sync #(.WIDTH(6)) u_sync (
		.clock(clock),
		.nrst(nrst),
		.din(sources),
		.dout(srcSync)
	);

	always_comb begin
		unique case (ctrl_ff.extResetSourceSel)
			ltrs_pkg::SRC_CAPCOMP: selSrc = srcSync.capcompOutput;
			ltrs_pkg::SRC_COMP_A: selSrc = srcSync.comparatorAOutput;
			ltrs_pkg::SRC_COMP_B: selSrc = srcSync.comparatorBOutput;
			ltrs_pkg::SRC_FAULT: selSrc = srcSync.outgenFaultInput;
			ltrs_pkg::SRC_OUT_ZERO: selSrc = srcSync.outgenOutputZero;
			ltrs_pkg::SRC_OUT_ONE: selSrc = srcSync.outgenOutputOne;
			default: selSrc = 1'b0;
		endcase
	end

	// ----------------------------------------------------------------
	// timer tick and event detection
	// ----------------------------------------------------------------
	assign tick = (div_ff == 2'(ltrs_pkg::TICK_DIV - 1));

	// edges between ticks are latched so a short pulse is not lost
	always_comb begin
		nxt_div = tick ? 2'h0 : div_ff + 2'h1;
		nxt_prev = selSrc;
		reqRise = riseSeen_ff | (selSrc & ~prev_ff);
		reqFall = fallSeen_ff | (~selSrc & prev_ff);
		if (!ctrl_ff.riseEdgeSensitive) begin
			reqRise = selSrc;
		end
		if (!ctrl_ff.fallEdgeSensitive) begin
			reqFall = ~selSrc;
		end
		reqRise = reqRise & ctrl_ff.riseEventResetEn;
		reqFall = reqFall & ctrl_ff.fallEventResetEn;
		// disabled edges are not remembered, so enabling later cannot replay them
		nxt_riseSeen = riseSeen_ff | (selSrc & ~prev_ff & ctrl_ff.riseEventResetEn);
		nxt_fallSeen = fallSeen_ff | (~selSrc & prev_ff & ctrl_ff.fallEventResetEn);
		nxt_clear = 1'b0;
		if (tick) begin
			nxt_riseSeen = 1'b0;
			nxt_fallSeen = 1'b0;
			nxt_clear = (reqRise | reqFall) & ~countWriteStrobe;
		end
		if (countWriteStrobe) begin
			nxt_riseSeen = 1'b0;
			nxt_fallSeen = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			div_ff <= 2'h0;
			prev_ff <= 1'b0;
			riseSeen_ff <= 1'b0;
			fallSeen_ff <= 1'b0;
			clear_ff <= 1'b0;
		end else begin
			div_ff <= nxt_div;
			prev_ff <= nxt_prev;
			riseSeen_ff <= nxt_riseSeen;
			fallSeen_ff <= nxt_fallSeen;
			clear_ff <= nxt_clear;
		end
	end

	// clear goes out with the first tick after the event; clear_ff only reports it
	assign timerTick = tick;
	assign countClear = nxt_clear;

	// ----------------------------------------------------------------
	// axi4-lite slave
	// ----------------------------------------------------------------
	assign doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;

	always_comb begin
		nxt_awHeld = awHeld_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wHeld = wHeld_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bValid = bValid_ff;
		nxt_bResp = bResp_ff;
		nxt_ctrl = ctrl_ff;
		nxt_rValid = rValid_ff;
		nxt_rData = rData_ff;
		nxt_rResp = rResp_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_awHeld = 1'b1;
			nxt_awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_wHeld = 1'b1;
			nxt_wData = s_axi_wdata;
			nxt_wStrb = s_axi_wstrb;
		end
		if (doWrite) begin
			nxt_awHeld = 1'b0;
			nxt_wHeld = 1'b0;
			nxt_bValid = 1'b1;
			nxt_bResp = 2'h0;
			if (awAddr_ff[3:2] == ltrs_pkg::CTRL_OFFSET[3:2]) begin
				if (wStrb_ff[0]) begin
					nxt_ctrl = ltrs_pkg::ltrs_ctrl_t'(wData_ff[7:0] & ltrs_pkg::CTRL_WMASK);
				end
			end else if (awAddr_ff[3:2] == ltrs_pkg::STATUS_OFFSET[3:2]) begin
				nxt_bResp = 2'h2;
			end else begin
				nxt_bResp = 2'h3;
			end
		end
		if (bValid_ff && s_axi_bready) begin
			nxt_bValid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rValid = 1'b1;
			nxt_rResp = 2'h0;
			nxt_rData = 32'h0000_0000;
			if (s_axi_araddr[3:2] == ltrs_pkg::CTRL_OFFSET[3:2]) begin
				nxt_rData[7:0] = ctrl_ff;
			end else if (s_axi_araddr[3:2] == ltrs_pkg::STATUS_OFFSET[3:2]) begin
				nxt_rData[3:0] = {clear_ff, selSrc, fallSeen_ff, riseSeen_ff};
			end else begin
				nxt_rResp = 2'h3;
			end
		end else if (rValid_ff && s_axi_rready) begin
			nxt_rValid = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			ctrl_ff <= ltrs_pkg::ltrs_ctrl_t'(ltrs_pkg::CTRL_RESET);
			awHeld_ff <= 1'b0;
			awAddr_ff <= 4'h0;
			wHeld_ff <= 1'b0;
			wData_ff <= 32'h0000_0000;
			wStrb_ff <= 4'h0;
			bValid_ff <= 1'b0;
			bResp_ff <= 2'h0;
			rValid_ff <= 1'b0;
			rData_ff <= 32'h0000_0000;
			rResp_ff <= 2'h0;
		end else begin
			ctrl_ff <= nxt_ctrl;
			awHeld_ff <= nxt_awHeld;
			awAddr_ff <= nxt_awAddr;
			wHeld_ff <= nxt_wHeld;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bValid_ff <= nxt_bValid;
			bResp_ff <= nxt_bResp;
			rValid_ff <= nxt_rValid;
			rData_ff <= nxt_rData;
			rResp_ff <= nxt_rResp;
		end
	end

	assign s_axi_awready = ~awHeld_ff & ~bValid_ff;
	assign s_axi_wready = ~wHeld_ff & ~bValid_ff;
	assign s_axi_bvalid = bValid_ff;
	assign s_axi_bresp = bResp_ff;
	assign s_axi_arready = ~rValid_ff;
	assign s_axi_rvalid = rValid_ff;
	assign s_axi_rdata = rData_ff;
	assign s_axi_rresp = rResp_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_clear_on_tick: assert property (@(posedge clock) disable iff (!nrst)
		countClear |-> tick)
		else $error("clear outside a timer tick");
	a_write_wins: assert property (@(posedge clock) disable iff (!nrst)
		countWriteStrobe |-> !countClear)
		else $error("clear issued during count write");
	a_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl_ff.extResetSourceSel[2:1] == 2'h3) |-> !selSrc)
		else $error("reserved select not zero");
	a_rise_disabled: assert property (@(posedge clock) disable iff (!nrst)
		(tick && !ctrl_ff.riseEventResetEn && !ctrl_ff.fallEventResetEn) |=> !clear_ff)
		else $error("clear with both enables off");
	a_level_rise: assert property (@(posedge clock) disable iff (!nrst)
		(tick && ctrl_ff.riseEventResetEn && !ctrl_ff.riseEdgeSensitive && selSrc
		&& !countWriteStrobe) |=> clear_ff)
		else $error("level rise did not clear");
	a_level_fall: assert property (@(posedge clock) disable iff (!nrst)
		(tick && ctrl_ff.fallEventResetEn && !ctrl_ff.fallEdgeSensitive && !selSrc
		&& !countWriteStrobe) |=> clear_ff)
		else $error("level fall did not clear");
	a_edge_fall: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl_ff.fallEventResetEn && ctrl_ff.fallEdgeSensitive
		&& $fell(selSrc) && !tick && !countWriteStrobe) |=> fallSeen_ff)
		else $error("falling edge not latched");
	a_edge_rise: assert property (@(posedge clock) disable iff (!nrst)
		(ctrl_ff.riseEventResetEn && ctrl_ff.riseEdgeSensitive && !ctrl_ff.fallEventResetEn
		&& $rose(selSrc) && !tick && !countWriteStrobe) |=> riseSeen_ff)
		else $error("rising edge not latched");
	a_tick_period: assert property (@(posedge clock) disable iff (!nrst)
		tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
		else $error("tick period not four clocks");

endmodule : ltrs_top

// >>> verif/ltrs_src_model.sv
`timescale 1ns/1ps
module ltrs_src_model (
	// clock
	input wire logic clock,
	// wanted levels, msb is the capture/compare output
	input wire logic [5:0] want,
	// peripheral outputs
	output ltrs_pkg::ltrs_sources_t sources
);
	// levels move only after a clock edge, as real peripheral outputs do
	always_ff @(posedge clock) begin
		sources <= want;
	end
endmodule : ltrs_src_model

// >>> verif/limit_timer_reset_select_tb.sv
`timescale 1ns/1ps
module limit_timer_reset_select_tb;
	logic clock = 0, nrst = 0, countWriteStrobe = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, timerTick, countClear;
	logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rnd = 32'h2CA0D680;
	logic [5:0] want = 0, m;
	ltrs_pkg::ltrs_sources_t sources;
	int fails = 0, n_tests = 0, clr, tk, k, b, acc;

	ltrs_src_model i_src (.clock, .want, .sources);
	ltrs_top i_dut (.clock, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sources,
		.countWriteStrobe, .timerTick, .countClear);

	initial forever #12.5 clock = ~clock;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs

	// sources bit of a select code, -1 for the reserved codes
	function automatic int srcBit(input int sel);
		return (sel < 6) ? 5 - sel : -1;
	endfunction : srcBit

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (i == 40) begin
			fails++;
			summarize();
		end
		chk(32'(s_axi_bresp), 32'(er));
	endtask : axw

	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (i == 40) begin
			fails++;
			summarize();
		end
		chk(32'(s_axi_rresp), 32'(er));
		if (er == 2'h0) chk(s_axi_rdata, ed);
	endtask : axr

	// sets the sources, then counts clears and ticks for n cycles
	task automatic drive(input logic [5:0] w, input int n, input int ec);
		@(posedge clock);
		want <= w;
		clr = 0;
		tk = 0;
		repeat (n) begin
			@(negedge clock);
			if (countClear === 1'b1) clr++;
			if (timerTick === 1'b1) tk++;
			if (countClear === 1'b1 && timerTick !== 1'b1) chk(0, 1);
		end
		if (ec >= 0) chk(32'(clr), 32'(ec));
	endtask : drive

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		axr(ltrs_pkg::CTRL_OFFSET, 32'(ltrs_pkg::CTRL_RESET), 2'h0);
		axw(ltrs_pkg::CTRL_OFFSET, 32'hFF, 2'h0);
		axr(ltrs_pkg::CTRL_OFFSET, 32'hDF, 2'h0);
		axr(ltrs_pkg::STATUS_OFFSET, 32'h0, 2'h0);
		axw(ltrs_pkg::STATUS_OFFSET, 32'h0, 2'h2);
		axr(4'h8, 32'h0, 2'h3);
		// random noise on the other sources must never clear
		for (k = 0; k < 8; k++) begin
			b = srcBit(k);
			m = (b >= 0) ? 6'(1 << b) : 6'h00;
			axw(ltrs_pkg::CTRL_OFFSET, 32'h41 | (k << 2), 2'h0);
			drive(6'h00, 16, -1);
			acc = 0;
			repeat (8) begin
				rnd = xs(rnd);
				drive(rnd[5:0] & ~m, 1, -1);
				acc += clr;
			end
			drive(6'h00, 24, -1);
			chk(32'(acc + clr), 32'h0);
			drive((b >= 0) ? m : 6'h3F, 24, (b >= 0) ? 1 : 0);
		end
		axw(ltrs_pkg::CTRL_OFFSET, 32'h8E, 2'h0);
		drive(6'h3F, 16, -1);
		drive(6'h00, 24, 1);
		axw(ltrs_pkg::CTRL_OFFSET, 32'h8C, 2'h0);
		drive(6'h3F, 16, -1);
		drive(6'h00, 24, 0);
		axw(ltrs_pkg::CTRL_OFFSET, 32'h4C, 2'h0);
		drive(6'h3F, 24, 0);
		axw(ltrs_pkg::CTRL_OFFSET, 32'h0D, 2'h0);
		drive(6'h3F, 16, -1);
		drive(6'h3F, 40, 10);
		chk(32'(tk), 32'h0000_000A);
		drive(6'h00, 16, -1);
		drive(6'h00, 40, 0);
		axw(ltrs_pkg::CTRL_OFFSET, 32'h0E, 2'h0);
		drive(6'h00, 16, -1);
		drive(6'h00, 40, 10);
		@(posedge clock);
		countWriteStrobe <= 1'b1;
		drive(6'h00, 40, 0);
		axw(ltrs_pkg::CTRL_OFFSET, 32'h4D, 2'h0);
		drive(6'h3F, 14, -1);
		acc = clr;
		@(posedge clock);
		countWriteStrobe <= 1'b0;
		drive(6'h3F, 16, -1);
		chk(32'(acc + clr), 32'h0);
		summarize();
	end
endmodule : limit_timer_reset_select_tb
